// ### bench/rfa_fb_properties.sv
`timescale 1ns/1ns
module rfa_fb_properties (
    input wire       i_mclk,
    input wire       i_sys_rst,
    input wire       i_soft_rst,
    input wire       i_wr_en,
    input wire       i_rd_en,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire [7:0] i_ro_value,
    input wire [7:0] i_w1c_set,
    input wire [7:0] i_rc_set,
    input wire [7:0] i_sticky_cond,
    input wire [7:0] o_rdata,
    input wire       o_rd_valid,
    input wire [7:0] o_keep_value,
    input wire [7:0] o_w1c_value,
    input wire [3:0] o_ll_value,
    input wire [3:0] o_lh_value,
    input wire [7:0] o_sticky_value
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst || i_soft_rst);
    // Read of the read-to-clear word, no set pending
    sequence rc_read;
        i_rd_en && i_addr == 4'h6 && i_rc_set == 8'h00;
    endsequence
    // Each read answered exactly one cycle later
    a_read_valid: assert property (1 |=> o_rd_valid == $past(i_rd_en))
        else $error("read valid timing");
    a_ro_read: assert property (i_rd_en && i_addr == 4'h2 && $stable(i_ro_value)
        |=> o_rdata == $past(i_ro_value)) else $error("read-only value");
    a_w1c_bit_clear: assert property (i_wr_en && i_addr == 4'h4 |=> o_w1c_value ==
        (($past(o_w1c_value) & ~$past(i_wdata)) | $past(i_w1c_set))) else $error("w1c");
    a_rc_read_clear: assert property (rc_read ##1 i_rc_set == 8'h00 ##1 rc_read
        |=> o_rdata == 8'h00) else $error("read-to-clear");
    a_latch_hold: assert property (!(i_rd_en && i_addr == 4'h7) |=>
        (o_lh_value & $past(o_lh_value)) == $past(o_lh_value) &&
        (o_ll_value | $past(o_ll_value)) == $past(o_ll_value)) else $error("latch hold");
    a_sticky_hold: assert property (!(i_rd_en && i_addr == 4'h9) |=>
        (o_sticky_value & $past(o_sticky_value)) == $past(o_sticky_value))
        else $error("sticky hold");
    a_sticky_reload: assert property (i_rd_en && i_addr == 4'h9 |=>
        o_sticky_value == $past(i_sticky_cond)) else $error("sticky reload");
    a_keep_soft: assert property (disable iff (i_sys_rst)
        i_soft_rst && !i_wr_en |=> $stable(o_keep_value)) else $error("keep field");
endmodule

// ### bench/tb_rfa_field_bank.sv
`timescale 1ns/1ns
module tb_rfa_field_bank;
    reg        i_mclk = 1'h0;
    reg        i_sys_rst = 1'h1;
    reg        i_soft_rst = 1'h0;
    reg        i_wr_en = 1'h0;
    reg        i_rd_en = 1'h0;
    reg  [3:0] i_addr = 4'h0, i_ll_cond = 4'hF, i_lh_cond = 4'h0, i_sc_done = 4'h0;
    reg  [3:0] i_ss_done = 4'h0;
    reg  [7:0] i_wdata = 8'h00, i_ro_value = 8'h00, i_w1c_set = 8'h00, i_wac_set = 8'h00;
    reg  [7:0] i_rc_set = 8'h00, i_sticky_cond = 8'h00;
    wire       o_rd_valid;
    wire [3:0] o_sc_value, o_ss_value, o_ll_value, o_lh_value;
    wire [7:0] o_rdata, o_rw_value, o_keep_value, o_wo_value, o_w1c_value, o_wac_value;
    wire [7:0] o_sticky_value;
    integer    failures = 0;
    integer    checks = 0;

    rfa_field_bank DUT (.i_mclk, .i_sys_rst, .i_soft_rst, .i_wr_en, .i_rd_en, .i_addr,
        .i_wdata, .i_ro_value, .i_w1c_set, .i_wac_set, .i_rc_set, .i_ll_cond, .i_lh_cond,
        .i_sticky_cond, .i_sc_done, .i_ss_done, .o_rdata, .o_rd_valid, .o_rw_value,
        .o_keep_value, .o_wo_value, .o_w1c_value, .o_wac_value, .o_sc_value, .o_ss_value,
        .o_ll_value, .o_lh_value, .o_sticky_value);

    // Clock, 100 ns period
    always #50 i_mclk = ~i_mclk;

    task tick; @(posedge i_mclk); endtask
    // Compare and count
    task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle write strobe
    task wr(input [3:0] a, input [7:0] d);
        tick;
        i_wr_en <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        tick;
        i_wr_en <= 1'h0;
        #1;
    endtask
    // One-cycle read strobe, answer one edge later
    task rd(input [3:0] a, input [7:0] e);
        tick;
        i_rd_en <= 1'h1;
        i_addr <= a;
        tick;
        i_rd_en <= 1'h0;
        #1;
        chk("rdata", o_rdata, e);
        chk("rd_valid", {7'h00, o_rd_valid}, 8'h01);
    endtask
    task t_plain;
        wr(4'h0, 8'hA5);
        wr(4'h1, 8'h3C);
        rd(4'h0, 8'hA5);
        tick;
        i_soft_rst <= 1'h1;
        i_ro_value <= 8'h5A;
        tick;
        i_soft_rst <= 1'h0;
        #1;
        chk("keep", o_keep_value, 8'h3C);
        chk("rw", o_rw_value, 8'h00);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h5A);
        wr(4'h3, 8'hC3);
        chk("wo", o_wo_value, 8'hC3);
        rd(4'h3, 8'h00);
        wr(4'hA, 8'h00);
        rd(4'hA, 8'h00);
        $display("test plain done");
    endtask
    task t_clear;
        tick;
        i_w1c_set <= 8'hF0;
        i_wac_set <= 8'h81;
        i_rc_set <= 8'h0F;
        tick;
        i_w1c_set <= 8'h00;
        i_wac_set <= 8'h01;
        i_rc_set <= 8'h00;
        wr(4'h4, 8'h30);
        chk("w1c", o_w1c_value, 8'hC0);
        wr(4'h5, 8'h00);
        chk("wac", o_wac_value, 8'h01);
        wr(4'h6, 8'hFF);
        rd(4'h6, 8'h0F);
        rd(4'h6, 8'h00);
        $display("test clear done");
    endtask
    task t_latch;
        tick;
        i_lh_cond <= 4'h2;
        i_ll_cond <= 4'hE;
        i_sticky_cond <= 8'h11;
        tick;
        i_lh_cond <= 4'h0;
        i_ll_cond <= 4'hF;
        i_sticky_cond <= 8'h01;
        tick;
        #1;
        chk("sticky", o_sticky_value, 8'h11);
        rd(4'h7, 8'h2E);
        chk("latch", {o_lh_value, o_ll_value}, 8'h0F);
        rd(4'h9, 8'h11);
        chk("sticky", o_sticky_value, 8'h01);
        $display("test latch done");
    endtask
    task t_self;
        wr(4'h8, 8'h05);
        rd(4'h8, 8'h05);
        tick;
        i_sc_done <= 4'h1;
        i_ss_done <= 4'h3;
        tick;
        i_sc_done <= 4'h0;
        i_ss_done <= 4'h0;
        wr(4'h8, 8'hF0);
        chk("self", {o_ss_value, o_sc_value}, 8'h34);
        tick;
        i_wr_en <= 1'h1;
        i_addr <= 4'h8;
        i_wdata <= 8'h00;
        i_ss_done <= 4'h1;
        tick;
        i_wr_en <= 1'h0;
        i_ss_done <= 4'h0;
        #1;
        chk("self_set", {o_ss_value, o_sc_value}, 8'h14);
        $display("test self done");
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence after 3 reset cycles
    initial begin
        repeat (3) tick;
        i_sys_rst <= 1'h0;
        t_plain;
        t_clear;
        t_latch;
        t_self;
        end_of_test;
    end
    // Cut a hung run short
    initial begin
        repeat (2000) tick;
        failures = failures + 1;
        end_of_test;
    end
endmodule
bind rfa_field_bank rfa_fb_properties u_chk (.i_mclk, .i_sys_rst, .i_soft_rst, .i_wr_en,
    .i_rd_en, .i_addr, .i_wdata, .i_ro_value, .i_w1c_set, .i_rc_set, .i_sticky_cond,
    .o_rdata, .o_rd_valid, .o_keep_value, .o_w1c_value, .o_ll_value, .o_lh_value,
    .o_sticky_value);

// ### logic/rfa_field_bank.v
`timescale 1ns/1ns
`include "rfa_regs.vh"

module rfa_field_bank (
    input  wire               i_mclk,
    input  wire               i_sys_rst,
    input  wire               i_soft_rst,
    input  wire               i_wr_en,
    input  wire               i_rd_en,
    input  wire [`RFA_AW-1:0] i_addr,
    input  wire [`RFA_DW-1:0] i_wdata,
    input  wire [`RFA_DW-1:0] i_ro_value,
    input  wire [`RFA_DW-1:0] i_w1c_set,
    input  wire [`RFA_DW-1:0] i_wac_set,
    input  wire [`RFA_DW-1:0] i_rc_set,
    input  wire [3:0]         i_ll_cond,
    input  wire [3:0]         i_lh_cond,
    input  wire [`RFA_DW-1:0] i_sticky_cond,
    input  wire [3:0]         i_sc_done,
    input  wire [3:0]         i_ss_done,
    output reg  [`RFA_DW-1:0] o_rdata,
    output reg                o_rd_valid,
    output wire [`RFA_DW-1:0] o_rw_value,
    output wire [`RFA_DW-1:0] o_keep_value,
    output wire [`RFA_DW-1:0] o_wo_value,
    output wire [`RFA_DW-1:0] o_w1c_value,
    output wire [`RFA_DW-1:0] o_wac_value,
    output wire [3:0]         o_sc_value,
    output wire [3:0]         o_ss_value,
    output wire [3:0]         o_ll_value,
    output wire [3:0]         o_lh_value,
    output wire [`RFA_DW-1:0] o_sticky_value
);

    // Field storage
    reg [`RFA_DW-1:0] rw_reg;
    reg [`RFA_DW-1:0] rw_next;
    reg [`RFA_DW-1:0] keep_reg;
    reg [`RFA_DW-1:0] keep_next;
    reg [`RFA_DW-1:0] wo_reg;
    reg [`RFA_DW-1:0] wo_next;
    reg [`RFA_DW-1:0] w1c_reg;
    reg [`RFA_DW-1:0] w1c_next;
    reg [`RFA_DW-1:0] wac_reg;
    reg [`RFA_DW-1:0] wac_next;
    reg [`RFA_DW-1:0] rc_reg;
    reg [`RFA_DW-1:0] rc_next;
    reg [3:0]         sc_reg;
    reg [3:0]         sc_next;
    reg [3:0]         ss_reg;
    reg [3:0]         ss_next;
    reg [`RFA_DW-1:0] rdata_next;

    // Access decode
    wire wr_rw     = i_wr_en && (i_addr == `RFA_ADDR_RW);
    wire wr_keep   = i_wr_en && (i_addr == `RFA_ADDR_KEEP);
    wire wr_wo     = i_wr_en && (i_addr == `RFA_ADDR_WO);
    wire wr_w1c    = i_wr_en && (i_addr == `RFA_ADDR_W1C);
    wire wr_wac    = i_wr_en && (i_addr == `RFA_ADDR_WAC);
    wire wr_self   = i_wr_en && (i_addr == `RFA_ADDR_SELF);
    wire rd_rc     = i_rd_en && (i_addr == `RFA_ADDR_RC);
    wire rd_latch  = i_rd_en && (i_addr == `RFA_ADDR_LATCH);
    wire rd_sticky = i_rd_en && (i_addr == `RFA_ADDR_STICKY);

    // Latch and sticky cells share one cell type
    wire [`RFA_LATCH_N-1:0] lat_cond = {i_sticky_cond, i_lh_cond, i_ll_cond};
    wire [`RFA_LATCH_N-1:0] lat_read;
    wire [`RFA_LATCH_N-1:0] lat_q;

    genvar g;
    generate
        for (g = 0; g < `RFA_LATCH_N; g = g + 1) begin : g_lat
            assign lat_read[g] = (g >= `RFA_STK_LSB) ? rd_sticky : rd_latch;
            rfa_latch_cell #(
                .ACT_HIGH ((g > `RFA_LL_TOP) ? 1'b1 : 1'b0)
            ) u_cell (
                .i_mclk     (i_mclk),
                .i_sys_rst  (i_sys_rst),
                .i_soft_rst (i_soft_rst),
                .i_cond     (lat_cond[g]),
                .i_read     (lat_read[g]),
                .o_q        (lat_q[g])
            );
        end
    endgenerate

    // Plain read-write, kept and write-only settings
    always @* begin
        rw_next   = rw_reg;
        keep_next = keep_reg;
        wo_next   = wo_reg;
        if (wr_rw) begin
            rw_next = i_wdata;
        end
        if (wr_keep) begin
            keep_next = i_wdata;
        end
        if (wr_wo) begin
            wo_next = i_wdata;
        end
    end

    // Event fields; the hardware set always wins over a clear
    always @* begin
        w1c_next = w1c_reg;
        wac_next = wac_reg;
        rc_next  = rc_reg;
        if (wr_w1c) begin
            w1c_next = w1c_reg & ~i_wdata;
        end
        w1c_next = w1c_next | i_w1c_set;
        if (wr_wac) begin
            wac_next = `RFA_RST_EVT;
        end
        wac_next = wac_next | i_wac_set;
        if (rd_rc) begin
            rc_next = `RFA_RST_EVT;
        end
        rc_next = rc_next | i_rc_set;
    end

    // Self-clearing and self-setting command bits
    always @* begin
        sc_next = sc_reg & ~i_sc_done;
        ss_next = ss_reg;
        if (wr_self) begin
            sc_next = sc_next | i_wdata[`RFA_LO_MSB:`RFA_LO_LSB];
            ss_next = ss_next & i_wdata[`RFA_HI_MSB:`RFA_HI_LSB];
        end
        ss_next = ss_next | i_ss_done;
    end

    // Read data, sampled before any clear-on-read lands
    always @* begin
        case (i_addr)
            `RFA_ADDR_RW:     rdata_next = rw_reg;
            `RFA_ADDR_KEEP:   rdata_next = keep_reg;
            `RFA_ADDR_RO:     rdata_next = i_ro_value;
            `RFA_ADDR_WO:     rdata_next = `RFA_RD_ZERO;
            `RFA_ADDR_W1C:    rdata_next = w1c_reg;
            `RFA_ADDR_WAC:    rdata_next = wac_reg;
            `RFA_ADDR_RC:     rdata_next = rc_reg;
            `RFA_ADDR_LATCH:  rdata_next = lat_q[`RFA_HI_MSB:`RFA_LO_LSB];
            `RFA_ADDR_SELF:   rdata_next = {ss_reg, sc_reg};
            `RFA_ADDR_STICKY: rdata_next = lat_q[`RFA_STK_MSB:`RFA_STK_LSB];
            default:          rdata_next = `RFA_RD_ZERO;
        endcase
    end

    // Kept field answers only to the hardware reset
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            keep_reg <= `RFA_RST_KEEP;
        end else begin
            keep_reg <= keep_next;
        end
    end

    // Ordinary fields answer to both resets
    always @(posedge i_mclk) begin
        if (i_sys_rst || i_soft_rst) begin
            rw_reg  <= `RFA_RST_RW;
            wo_reg  <= `RFA_RST_WO;
            w1c_reg <= `RFA_RST_EVT;
            wac_reg <= `RFA_RST_EVT;
            rc_reg  <= `RFA_RST_EVT;
            sc_reg  <= `RFA_RST_SC;
            ss_reg  <= `RFA_RST_SS;
        end else begin
            rw_reg  <= rw_next;
            wo_reg  <= wo_next;
            w1c_reg <= w1c_next;
            wac_reg <= wac_next;
            rc_reg  <= rc_next;
            sc_reg  <= sc_next;
            ss_reg  <= ss_next;
        end
    end

    // Read answer one edge after the strobe
    always @(posedge i_mclk) begin
        if (i_sys_rst || i_soft_rst) begin
            o_rdata    <= `RFA_RD_ZERO;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rdata_next;
            end
        end
    end

    // Field values to the hardware side
    assign o_rw_value     = rw_reg;
    assign o_keep_value   = keep_reg;
    assign o_wo_value     = wo_reg;
    assign o_w1c_value    = w1c_reg;
    assign o_wac_value    = wac_reg;
    assign o_sc_value     = sc_reg;
    assign o_ss_value     = ss_reg;
    assign o_ll_value     = lat_q[`RFA_LO_MSB:`RFA_LO_LSB];
    assign o_lh_value     = lat_q[`RFA_HI_MSB:`RFA_HI_LSB];
    assign o_sticky_value = lat_q[`RFA_STK_MSB:`RFA_STK_LSB];
endmodule

// ### logic/rfa_latch_cell.v
`timescale 1ns/1ns
`include "rfa_regs.vh"

module rfa_latch_cell #(
    parameter ACT_HIGH = 1'b1
) (
    input  wire i_mclk,
    input  wire i_sys_rst,
    input  wire i_soft_rst,
    input  wire i_cond,
    input  wire i_read,
    output wire o_q
);
    localparam IDLE = ~ACT_HIGH;

    reg q_reg;
    reg q_next;

    // Latch the active level; a read reloads the live condition
    always @* begin
        if (i_read) begin
            q_next = i_cond;
        end else if (ACT_HIGH) begin
            q_next = q_reg | i_cond;
        end else begin
            q_next = q_reg & i_cond;
        end
    end

    // Both resets return the cell to its idle level
    always @(posedge i_mclk) begin
        if (i_sys_rst || i_soft_rst) begin
            q_reg <= IDLE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;
endmodule

// ### logic/rfa_regs.vh
`ifndef RFA_REGS_VH
`define RFA_REGS_VH

// Port widths and latch cell count
`define RFA_DW          8
`define RFA_AW          4
`define RFA_LATCH_N     16

// Word addresses
`define RFA_ADDR_RW     4'h0
`define RFA_ADDR_KEEP   4'h1
`define RFA_ADDR_RO     4'h2
`define RFA_ADDR_WO     4'h3
`define RFA_ADDR_W1C    4'h4
`define RFA_ADDR_WAC    4'h5
`define RFA_ADDR_RC     4'h6
`define RFA_ADDR_LATCH  4'h7
`define RFA_ADDR_SELF   4'h8
`define RFA_ADDR_STICKY 4'h9

// Field positions inside a word
`define RFA_LO_MSB      3
`define RFA_LO_LSB      0
`define RFA_HI_MSB      7
`define RFA_HI_LSB      4

// Latch cell groups by index
`define RFA_LL_TOP      3
`define RFA_STK_LSB     8
`define RFA_STK_MSB     15

// Reset values
`define RFA_RST_RW      8'h00
`define RFA_RST_KEEP    8'h00
`define RFA_RST_WO      8'h00
`define RFA_RST_EVT     8'h00
`define RFA_RST_SC      4'h0
`define RFA_RST_SS      4'hF
`define RFA_RD_ZERO     8'h00

`endif
